// *** verilog/acc_pkg.sv ***
/*
 * Package for the analog comparator control block: register offsets, field
 * positions, reset values, encodings and the structs carried on its ports.
 * Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
 */
// Behaviour
// - Sense code 00 flags every output change
// - Code 10 falling edge, 11 rising edge
// - Neg select 000..011 reference fraction taps
// - Neg select 100..111 bandgap, converter, pins
// - Control bit 7 enables the comparator
// - Control bit 6 gates interrupt request
// - Comparator 3 bit 3 enables alternate pin
// - Extended bit 5 inverts comparator output
// - Extended bit 4 enables output pin drive
// - Extended bit 3 routes comparator 1 to capture
// - Capture edge select picks rising or falling
// - Hysteresis select code driven to analog core
// - Status bits 7..5 flag comparator events
// - Flag clears on vector acknowledge if enabled
// - Write one clears flag, zero keeps
// - Event flags offered as converter triggers
// - Status bits 3..1 show live outputs
// - Input disable bit forces pin read zero
// - Output high when positive exceeds negative
package acc_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ACC_OFS_CTL1  = 8'h00;
   localparam logic [7:0] ACC_OFS_CTL2  = 8'h04;
   localparam logic [7:0] ACC_OFS_CTL3  = 8'h08;
   localparam logic [7:0] ACC_OFS_ECTL  = 8'h0C;
   localparam logic [7:0] ACC_OFS_STAT  = 8'h10;
   localparam logic [7:0] ACC_OFS_DIS0  = 8'h14;
   localparam logic [7:0] ACC_OFS_DIS1  = 8'h18;

   localparam logic [7:0] ACC_RST_BYTE  = 8'h00;
   localparam logic [7:0] ACC_DIS1_MASK = 8'h09;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int ACC_B_EN      = 7;
   localparam int ACC_B_IE      = 6;
   localparam int ACC_B_SHI     = 5;
   localparam int ACC_B_SLO     = 4;
   localparam int ACC_B_ALT     = 3;
   localparam int ACC_B_INV     = 5;
   localparam int ACC_B_OE      = 4;
   localparam int ACC_B_ICE     = 3;
   localparam int ACC_B_FLAG0   = 5;
   localparam int ACC_B_LIVE0   = 1;
   localparam int ACC_NCMP      = 3;

   // ------------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] ACC_SENSE_TOGGLE = 2'h0;
   localparam logic [1:0] ACC_SENSE_RSVD   = 2'h1;
   localparam logic [1:0] ACC_SENSE_FALL   = 2'h2;
   localparam logic [1:0] ACC_SENSE_RISE   = 2'h3;

   localparam logic [1:0] ACC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ACC_HTRANS_SEQ    = 2'h3;

   // Negative input tap codes: 0..3 reference fractions, 4 bandgap,
   // 5 converter, 6 own pin, 7 shared pin.
   typedef enum logic [2:0] {
      ACC_NEG_DIV640  = 3'h0,
      ACC_NEG_DIV320  = 3'h1,
      ACC_NEG_DIV213  = 3'h2,
      ACC_NEG_DIV160  = 3'h3,
      ACC_NEG_BANDGAP = 3'h4,
      ACC_NEG_DAC     = 3'h5,
      ACC_NEG_OWNPIN  = 3'h6,
      ACC_NEG_SHARED  = 3'h7
   } acc_neg_e;

   // Per-comparator controls driven to one analog core.
   typedef struct packed {
      logic       on;
      logic [2:0] neg_sel;
      logic [2:0] hyst_sel;
   } acc_core_s;

   // Link to the timer input capture front end.
   typedef struct packed {
      logic route_en;
      logic cmp_level;
   } acc_capture_s;

endpackage : acc_pkg

// *** verilog/acc_top.sv ***
/*
 * Control and status logic for three analog comparators, an AHB-Lite slave.
 * Assumes the analog cores deliver asynchronous outputs and the interrupt
 * controller returns a one-cycle acknowledge per comparator vector.
 */
// Added by the designer: the placing of the registers and the AHB-Lite register port.
module acc_top
   import acc_pkg::*;
(
   input  wire logic                  i_clock,        // 40 MHz system clock
   input  wire logic                  i_nrst,         // Synchronous reset, low
   input  wire logic                  i_hsel,         // AHB slave select
   input  wire logic [7:0]            i_haddr,        // AHB address (low bits)
   input  wire logic [1:0]            i_htrans,       // AHB transfer type
   input  wire logic                  i_hwrite,       // AHB write
   input  wire logic [2:0]            i_hsize,        // AHB size
   input  wire logic                  i_hready,       // AHB bus ready
   input  wire logic [31:0]           i_hwdata,       // AHB write data
   output logic [31:0]                o_hrdata,       // AHB read data
   output logic                       o_hreadyout,    // AHB slave ready
   output logic                       o_hresp,        // AHB response
   input  wire logic [2:0]            i_cmp_raw,      // Async core outputs
   input  wire logic [2:0]            i_irq_ack,      // Vector taken, pulse
   input  wire logic                  i_capture_edge_sel, // Timer edge select
   input  wire logic [15:0]           i_pin_raw,      // Async pin levels
   output acc_pkg::acc_core_s [2:0]   o_core,         // Core controls
   output logic [2:0]                 o_irq,          // Interrupt requests
   output logic [2:0]                 o_conv_trigger, // Converter triggers
   output logic                       o_cmp_pin,      // Output pin level
   output logic                       o_cmp_pin_oe,   // Output pin enable
   output logic                       o_cmp3_alt_pin, // Alternate pin level
   output logic                       o_cmp3_alt_pin_oe, // Alternate pin enable
   output acc_pkg::acc_capture_s      o_capture,      // Capture front end
   output logic                       o_capture_event, // Capture edge pulse
   output logic [15:0]                o_pin_in,       // Gated pin inputs
   output logic [15:0]                o_buf_disable   // Input buffer disables
);
   import acc_pkg::*;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [7:0]  ctl_q [ACC_NCMP];
   logic [7:0]  ectl_q;
   logic [7:0]  dis0_q;
   logic [7:0]  dis1_q;
   logic [2:0]  flag_q;
   logic [2:0]  sync1_q, sync2_q, prev_q;
   logic [15:0] pin1_q, pin2_q;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [2:0]  cmp_q;
   logic        cap_prev_q;

   // ------------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ------------------------------------------------------------------
   logic       addr_ok;
   logic       wr_fire;
   logic [7:0] wbyte;
   assign addr_ok = i_hsel && i_hready && (i_htrans == ACC_HTRANS_NONSEQ || i_htrans == ACC_HTRANS_SEQ);
   assign wr_fire = wr_pend_q;
   assign wbyte   = i_hwdata[7:0];

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && i_hwrite;
         wr_addr_q <= i_haddr;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   // Read data is registered in the address phase so it stands on the
   // data-phase edge; live bits therefore lag the sampled state by a cycle.
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (i_haddr)
         ACC_OFS_CTL1: rd_byte = ctl_q[0];
         ACC_OFS_CTL2: rd_byte = ctl_q[1];
         ACC_OFS_CTL3: rd_byte = ctl_q[2];
         ACC_OFS_ECTL: rd_byte = ectl_q;
         ACC_OFS_STAT: rd_byte = {flag_q, 1'b0, cmp_q, 1'b0};
         ACC_OFS_DIS0: rd_byte = dis0_q;
         ACC_OFS_DIS1: rd_byte = dis1_q;
         default:      rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) o_hrdata <= 32'h0000_0000;
      else if (addr_ok && !i_hwrite) o_hrdata <= {24'h00_0000, rd_byte};
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         for (int i = 0; i < ACC_NCMP; i++) ctl_q[i] <= ACC_RST_BYTE;
         ectl_q <= ACC_RST_BYTE;
         dis0_q <= ACC_RST_BYTE;
         dis1_q <= ACC_RST_BYTE;
      end else if (wr_fire) begin
         unique case (wr_addr_q)
            ACC_OFS_CTL1: ctl_q[0] <= {wbyte[7:4], 1'b0, wbyte[2:0]};
            ACC_OFS_CTL2: ctl_q[1] <= {wbyte[7:4], 1'b0, wbyte[2:0]};
            ACC_OFS_CTL3: ctl_q[2] <= wbyte;
            ACC_OFS_ECTL: ectl_q   <= {2'h0, wbyte[5:0]};
            ACC_OFS_DIS0: dis0_q   <= wbyte;
            ACC_OFS_DIS1: dis1_q   <= wbyte & ACC_DIS1_MASK;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Comparator output synchronisers and edge detection
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q  <= 3'h0;
      end else begin
         sync1_q <= i_cmp_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // A disabled comparator reads low; both samples share the current enable, so enabling it alone raises no flag.
   logic [2:0] live;
   logic [2:0] live_prev;
   logic [2:0] hit;
   always_comb begin
      for (int i = 0; i < ACC_NCMP; i++) begin
         live[i]      = sync2_q[i] & ctl_q[i][ACC_B_EN];
         live_prev[i] = prev_q[i] & ctl_q[i][ACC_B_EN];
         unique case ({ctl_q[i][ACC_B_SHI], ctl_q[i][ACC_B_SLO]})
            ACC_SENSE_TOGGLE: hit[i] = live[i] ^ live_prev[i];
            ACC_SENSE_FALL:   hit[i] = !live[i] && live_prev[i];
            ACC_SENSE_RISE:   hit[i] = live[i] && !live_prev[i];
            default:          hit[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) cmp_q <= 3'h0;
      else cmp_q <= live;
   end

   // ------------------------------------------------------------------
   // Event flags: a new event wins over any clear in the same cycle
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         flag_q <= 3'h0;
      end else begin
         for (int i = 0; i < ACC_NCMP; i++) begin
            if (hit[i])
               flag_q[i] <= 1'b1;
            else if (wr_fire && wr_addr_q == ACC_OFS_STAT && wbyte[ACC_B_FLAG0 + i])
               flag_q[i] <= 1'b0;
            else if (i_irq_ack[i] && ctl_q[i][ACC_B_IE])
               flag_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_irq          <= 3'h0;
         o_conv_trigger <= 3'h0;
      end else begin
         for (int i = 0; i < ACC_NCMP; i++) begin
            o_irq[i]          <= (flag_q[i] | hit[i]) & ctl_q[i][ACC_B_IE];
            o_conv_trigger[i] <= flag_q[i] | hit[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // Core controls, output pins and capture routing
   // ------------------------------------------------------------------
   logic cmp1_out;
   logic cmp3_out;
   assign cmp1_out = live[0] ^ ectl_q[ACC_B_INV];
   assign cmp3_out = live[2] ^ ectl_q[ACC_B_INV];

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         for (int i = 0; i < ACC_NCMP; i++) o_core[i] <= '0;
      end else begin
         for (int i = 0; i < ACC_NCMP; i++) begin
            o_core[i].on       <= ctl_q[i][ACC_B_EN];
            o_core[i].neg_sel  <= ctl_q[i][2:0];
            o_core[i].hyst_sel <= ectl_q[2:0];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_cmp_pin         <= 1'b0;
         o_cmp_pin_oe      <= 1'b0;
         o_cmp3_alt_pin    <= 1'b0;
         o_cmp3_alt_pin_oe <= 1'b0;
      end else begin
         o_cmp_pin         <= cmp1_out;
         o_cmp_pin_oe      <= ectl_q[ACC_B_OE];
         o_cmp3_alt_pin    <= cmp3_out;
         o_cmp3_alt_pin_oe <= ctl_q[2][ACC_B_ALT];
      end
   end

   // The timer owns its own noise canceller; this edge pulse only mirrors
   // the selected edge so the routing can be observed at the boundary.
   logic cap_lvl;
   assign cap_lvl = cmp1_out & ectl_q[ACC_B_ICE];

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_capture       <= '0;
         o_capture_event <= 1'b0;
         cap_prev_q      <= 1'b0;
      end else begin
         cap_prev_q          <= cap_lvl;
         o_capture.route_en  <= ectl_q[ACC_B_ICE];
         o_capture.cmp_level <= cap_lvl;
         o_capture_event     <= ectl_q[ACC_B_ICE] &&
            (i_capture_edge_sel ? (cap_lvl && !cap_prev_q)
                                : (!cap_lvl && cap_prev_q));
      end
   end

   // ------------------------------------------------------------------
   // Pin input buffers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         pin1_q        <= 16'h0000;
         pin2_q        <= 16'h0000;
         o_pin_in      <= 16'h0000;
         o_buf_disable <= 16'h0000;
      end else begin
         pin1_q        <= i_pin_raw;
         pin2_q        <= pin1_q;
         o_buf_disable <= {dis1_q, dis0_q};
         o_pin_in      <= pin2_q & ~{dis1_q, dis0_q};
      end
   end

endmodule : acc_top

// *** bench/acc_top_sva.sv ***
/* Port checker for acc_top.
   Assumes it is bound onto acc_top. */
module acc_chk
   import acc_pkg::*;
(
   input wire logic                    i_clock,        // Clock
   input wire logic                    i_nrst,         // Reset, low
   input wire logic                    i_hsel,         // Select
   input wire logic [1:0]              i_htrans,       // Type
   input wire logic                    i_hwrite,       // Write
   input wire logic                    i_hready,       // Ready
   input wire logic [2:0]              i_irq_ack,      // Acks
   input wire logic [2:0]              o_irq,          // Requests
   input wire logic [2:0]              o_conv_trigger, // Triggers
   input wire acc_pkg::acc_core_s [2:0] o_core,        // Cores
   input wire logic [15:0]             o_pin_in,       // Pin inputs
   input wire logic [15:0]             o_buf_disable,  // Disables
   input wire acc_pkg::acc_capture_s   o_capture,      // Capture
   input wire logic                    o_capture_event // Capture pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------
   // Recent writes and acks; effects may lag a few edges.
   // -----------------------------------------------------------
   logic [3:0] wr_q;
   logic [3:0] ack_q;
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         wr_q  <= 4'h0;
         ack_q <= 4'h0;
      end else begin
         wr_q  <= {wr_q[2:0], i_hsel & i_hready & i_htrans[1] & i_hwrite};
         ack_q <= {ack_q[2:0], |i_irq_ack};
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   property p_irq_gate;
      (o_irq & ~o_conv_trigger) == 3'h0;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without flag");
   property p_core_wr;
      o_core != $past(o_core) |-> |wr_q;
   endproperty
   a_core_wr: assert property (p_core_wr) else $error("core moved unwritten");
   property p_buf_wr;
      $changed(o_buf_disable) |-> |wr_q;
   endproperty
   a_buf_wr: assert property (p_buf_wr) else $error("disable moved unwritten");
   property p_pin_gate;
      (o_pin_in & o_buf_disable & $past(o_buf_disable)) == 16'h0;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled pin read one");
   property p_route;
      !o_capture.route_en && !$past(o_capture.route_en) |-> !o_capture_event;
   endproperty
   a_route: assert property (p_route) else $error("capture while unrouted");
   property p_trig_clr;
      (~o_conv_trigger & $past(o_conv_trigger)) != 3'h0 |-> |(wr_q | ack_q);
   endproperty
   a_trig_clr: assert property (p_trig_clr) else $error("flag fell unasked");
   property p_hyst;
      o_core[0].hyst_sel == o_core[1].hyst_sel && o_core[1].hyst_sel == o_core[2].hyst_sel;
   endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis differs");
   property p_irq_fall;
      (~o_irq & $past(o_irq)) != 3'h0 |-> |(wr_q | ack_q);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
endmodule : acc_chk

bind acc_top acc_chk u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hready(i_hready), .i_irq_ack(i_irq_ack), .o_irq(o_irq),
   .o_conv_trigger(o_conv_trigger), .o_core(o_core), .o_pin_in(o_pin_in), .o_buf_disable(o_buf_disable),
   .o_capture(o_capture), .o_capture_event(o_capture_event));

// *** bench/acc_core_model.sv ***
/* Behavioural analog comparator cores.
   Assumes the bench gives positive inputs in millivolts. */
module acc_core_model
   import acc_pkg::*;
#(
   parameter int VREF_MV = 2560, // Reference
   parameter int BG_MV   = 1100, // Bandgap
   parameter int DAC_MV  = 900,  // Converter
   parameter int PIN_MV  = 500,  // Own pin
   parameter int SHR_MV  = 1500  // Shared pin
)
(
   input wire acc_pkg::acc_core_s [2:0] i_core,   // Controls
   input wire logic [2:0][11:0]         i_pos_mv, // Positive inputs
   output logic [2:0]                   o_raw     // Outputs
);
   timeunit 1ns;
   timeprecision 100ps;
   function automatic int neg_mv(input logic [2:0] sel);
      case (sel)
         3'h0: return VREF_MV * 100 / 640;
         3'h1: return VREF_MV * 100 / 320;
         3'h2: return VREF_MV * 100 / 213;
         3'h3: return VREF_MV * 100 / 160;
         3'h4: return BG_MV;
         3'h5: return DAC_MV;
         3'h6: return PIN_MV;
         default: return SHR_MV;
      endcase
   endfunction : neg_mv
   // A core that is off rests low; enabling it with its positive input above the threshold, or moving that input across it, gives an edge.
   always_comb begin
      for (int k = 0; k < 3; k++) o_raw[k] = i_core[k].on && (int'(i_pos_mv[k]) > neg_mv(i_core[k].neg_sel));
   end
endmodule : acc_core_model

// *** bench/acc_top_tb.sv ***
/* Testbench for acc_top with the core model.
   Assumes one AHB-Lite master and no other slave. */
module acc_top_tb
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              i_clock, i_nrst, hsel, hwrite, esel, rdy, resp, cpin, cpoe, apin, apoe, cev;
   logic [7:0]        haddr;
   logic [1:0]        htrans;
   logic [31:0]       hwdata, hrdata, rd;
   logic [2:0]        ack, raw, irq, trig;
   logic [15:0]       pin_raw, pin_in, bdis;
   logic [2:0][11:0]  pos;
   acc_core_s [2:0]   core;
   acc_capture_s      cap;
   int                err_total, n_compared, cap_cnt;
   logic [7:0]        wa [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
   logic [7:0]        wx [6] = '{8'hF7, 8'hF7, 8'hFF, 8'h3F, 8'hFF, 8'h09};
   acc_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(rdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
      .o_hreadyout(rdy), .o_hresp(resp), .i_cmp_raw(raw), .i_irq_ack(ack), .i_capture_edge_sel(esel),
      .i_pin_raw(pin_raw), .o_core(core), .o_irq(irq), .o_conv_trigger(trig), .o_cmp_pin(cpin),
      .o_cmp_pin_oe(cpoe), .o_cmp3_alt_pin(apin), .o_cmp3_alt_pin_oe(apoe), .o_capture(cap),
      .o_capture_event(cev), .o_pin_in(pin_in), .o_buf_disable(bdis));
   acc_core_model u_model (.i_core(core), .i_pos_mv(pos), .o_raw(raw));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) if (cev === 1'b1) cap_cnt++;
   // -----------------------------------------------------------
   // Bus and compare tasks
   // -----------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= ACC_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge i_clock); while (rdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clock); while (rdy !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rchk
   task automatic idle(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : idle
   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      #2000000;
      err_total++;
      finish_test();
   end
   // -----------------------------------------------------------
   // Tests
   // -----------------------------------------------------------
   initial begin
      {i_nrst, hsel, hwrite, esel, haddr, htrans, hwdata, ack, pos} = '0;
      pin_raw = 16'hFFFF;
      err_total = 0;
      n_compared = 0;
      cap_cnt = 0;
      repeat (5) @(posedge i_clock);
      i_nrst <= 1'b1;
      for (int a = 0; a <= 28; a += 4) rchk(8'(a), 32'h0);
      bus(1'b1, 8'h1C, 32'hFF);
      rchk(8'h1C, 32'h0);
      $display("test reset done");
      foreach (wa[i]) bus(1'b1, wa[i], 32'hFFFF_FFFF);
      foreach (wa[i]) rchk(wa[i], {24'h0, wx[i]});
      idle(4);
      for (int k = 0; k < 3; k++) check({25'h0, core[k]}, 32'h7F);
      check({28'h0, cpoe, apoe, cap.route_en, 1'b1}, 32'hF);
      check({bdis, pin_in}, 32'h09FF_F600);
      foreach (wa[i]) bus(1'b1, wa[i], 32'h0);
      idle(6);
      check({bdis, pin_in}, 32'h0000_FFFF);
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'(4 * k), {24'h0, 2'b11, 2'(c), 4'h0});
            bus(1'b1, ACC_OFS_STAT, 32'hE0);
            pos[k] <= 12'd2000;
            idle(8);
            check({29'h0, irq[k], trig[k], 1'b1}, {29'h0, {2{c == 0 || c == 3}}, 1'b1});
            rchk(ACC_OFS_STAT, ((c == 0 || c == 3) << (5 + k)) | (1 << (1 + k)));
            bus(1'b1, ACC_OFS_STAT, 32'hFF);
            rchk(ACC_OFS_STAT, 1 << (1 + k));
            pos[k] <= 12'd0;
            idle(8);
            rchk(ACC_OFS_STAT, (c == 0 || c == 2) << (5 + k));
            bus(1'b1, ACC_OFS_STAT, 32'hE0);
         end
      end
      $display("test sense done");
      bus(1'b1, ACC_OFS_CTL1, 32'h80);
      pos[0] <= 12'd2000;
      idle(8);
      bus(1'b1, ACC_OFS_STAT, 32'h0);
      ack <= 3'h1;
      idle(1);
      ack <= 3'h0;
      idle(2);
      check({31'h0, irq[0]}, 32'h0);
      rchk(ACC_OFS_STAT, 32'h22);
      bus(1'b1, ACC_OFS_CTL1, 32'hC0);
      idle(3);
      check({31'h0, irq[0]}, 32'h1);
      ack <= 3'h1;
      idle(1);
      ack <= 3'h0;
      idle(3);
      rchk(ACC_OFS_STAT, 32'h02);
      $display("test clear done");
      bus(1'b1, ACC_OFS_CTL3, 32'h88);
      pos[2] <= 12'd2000;
      bus(1'b1, ACC_OFS_ECTL, 32'h10);
      idle(8);
      check({29'h0, cpin, apin, apoe}, 32'h7);
      bus(1'b1, ACC_OFS_ECTL, 32'h30);
      idle(4);
      check({29'h0, cpin, apin, cpoe}, 32'h1);
      $display("test pins done");
      bus(1'b1, ACC_OFS_ECTL, 32'h08);
      pos[0] <= 12'd0;
      esel <= 1'b1;
      idle(8);
      cap_cnt = 0;
      for (int e = 0; e < 3; e++) begin
         pos[0] <= 12'd2000;
         idle(8);
         check({30'h0, resp, cap.cmp_level}, {31'h0, e < 2});
         pos[0] <= 12'd0;
         idle(8);
         check(cap_cnt, (e < 2) ? e + 1 : 2);
         esel <= (e == 0) ? 1'b0 : 1'b1;
         if (e == 1) bus(1'b1, ACC_OFS_ECTL, 32'h0);
         idle(4);
      end
      check(cap_cnt, 2);
      $display("test capture done");
      pos[0] <= 12'd1000;
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, ACC_OFS_CTL1, 32'h80 | i);
         bus(1'b1, ACC_OFS_ECTL, i);
         idle(8);
         check({26'h0, core[2].hyst_sel, core[0].neg_sel}, {26'h0, 3'(i), 3'(i)});
         bus(1'b0, ACC_OFS_STAT, 32'h0);
         check({31'h0, rd[1]}, {31'h0, 1'(8'h63 >> i)});
      end
      $display("test select done");
      finish_test();
   end
endmodule : acc_top_tb
